// ### uies_core.sv
// interrupt enable, prioritised status, line status and enhanced registers of one channel
//
// The implementer's own choice: strobed register access.
`include "uies_defs.svh"
module uies_core #(
  parameter int LVL_W = 6
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // register port
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [7:0] RD_DATA,
  // receive path status
  input wire logic [LVL_W-1:0] RX_FIFO_LEVEL,
  input wire logic [7:0] RX_HEAD_DATA,
  input wire logic [2:0] RX_HEAD_ERR,
  input wire logic RX_HEAD_NEW,
  input wire logic RX_CHAR_LOADED,
  input wire logic RX_OVERRUN,
  input wire logic RX_FIFO_HAS_ERR,
  input wire logic XOFF_DET,
  input wire logic XON_DET,
  input wire logic SPECIAL_DET,
  input wire logic BIT_TICK,
  // transmit path status
  input wire logic [LVL_W-1:0] TX_FIFO_LEVEL,
  input wire logic TSR_EMPTY,
  input wire logic RTS_N_STATE,
  // modem pins
  input wire logic CTS_N,
  input wire logic DSR_N,
  input wire logic RI_N,
  input wire logic CD_N,
  // outputs to the channel
  output logic IRQ,
  output logic RHR_RD,
  output logic THR_WR,
  output logic [7:0] THR_DATA,
  output logic RX_FIFO_RST,
  output logic TX_FIFO_RST,
  output logic FIFO_EN,
  output logic POLLED_MODE,
  output logic SLEEP_EN,
  output logic [7:0] LINE_CTRL,
  output logic [7:0] MODEM_CTRL,
  output logic [7:0] ENH_CTRL,
  output logic [15:0] DIVISOR,
  output logic [7:0] DIV_FRAC,
  output logic [31:0] FLOW_CHARS
);
  uies_pkg::uies_byte_t ier_q, lcr_q, mcr_q, efr_q, spr_q, dll_q, dlm_q, dld_q;
  uies_pkg::uies_byte_t xon_char_first_q, xon_char_second_q, xoff_char_first_q, xoff_char_second_q, rd_d, rd_q, thr_q;
  logic [7:0] fcr_q;
  logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q, msr_delta_q;
  logic [LVL_W-1:0] tx_lvl_q;
  logic [6:0] to_cnt_q, to_lim;
  logic [5:0] rx_trig, tx_trig, isr_code;
  logic enh_bank, dlab, enh, fifo_on, ovr_q, ls_pend_q, to_q, tx_pend_q;
  logic xoff_pend_q, spec_pend_q, flow_pend_q, rts_q, irq_q, thr_wr_q, rx_rst_q, tx_rst_q;
  logic wr_ier, wr_fcr, rd_isr, rd_lsr, rd_msr, rd_rhr, wr_thr;
  logic rx_hit, tx_event, tx_empty, ls_on, to_on, rx_on, tx_on, ms_on, xo_on, fl_on;
  uies_pkg::uies_src_t src;
  uies_pkg::uies_byte_t ier_eff, line_status_reg;

  assign enh_bank = (lcr_q == `UIES_LCR_ENH);
  assign dlab = lcr_q[`UIES_LCR_DLAB] & ~enh_bank;
  assign enh = efr_q[`UIES_EFR_ENH];
  assign ier_eff = {ier_q[7:4] & {4{enh}}, ier_q[3:0]};
  assign fifo_on = fcr_q[`UIES_FCR_EN];

  assign wr_ier = WR_STB & ~enh_bank & ~dlab & (ADDR == `UIES_A_IER);
  assign wr_fcr = WR_STB & ~enh_bank & (ADDR == `UIES_A_ISR) & ~dlab;
  assign wr_thr = WR_STB & ~enh_bank & ~dlab & (ADDR == `UIES_A_DATA);
  assign rd_rhr = RD_STB & ~enh_bank & ~dlab & (ADDR == `UIES_A_DATA);
  assign rd_isr = RD_STB & ~enh_bank & ~dlab & (ADDR == `UIES_A_ISR);
  assign rd_lsr = RD_STB & ~enh_bank & (ADDR == `UIES_A_LSR);
  assign rd_msr = RD_STB & ~enh_bank & (ADDR == `UIES_A_MSR);

  // config registers written by software
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ier_q <= 8'h00;
      lcr_q <= `UIES_LCR_RST;
      mcr_q <= 8'h00;
      efr_q <= 8'h00;
      spr_q <= 8'h00;
      dll_q <= 8'h00;
      dlm_q <= 8'h00;
      dld_q <= 8'h00;
      xon_char_first_q <= 8'h00;
      xon_char_second_q <= 8'h00;
      xoff_char_first_q <= 8'h00;
      xoff_char_second_q <= 8'h00;
      fcr_q <= 8'h00;
    end else if (WR_STB) begin
      if (ADDR == `UIES_A_LCR) begin
        lcr_q <= WR_DATA;
      end else if (enh_bank) begin
        unique case (ADDR)
          `UIES_A_EFR: efr_q <= WR_DATA;
          `UIES_A_XON_CHAR_FIRST: xon_char_first_q <= WR_DATA;
          `UIES_A_XON_CHAR_SECOND: xon_char_second_q <= WR_DATA;
          `UIES_A_XOFF_CHAR_FIRST: xoff_char_first_q <= WR_DATA;
          `UIES_A_XOFF_CHAR_SECOND: xoff_char_second_q <= WR_DATA;
          default: ;
        endcase
      end else if (dlab && ADDR == `UIES_A_DATA) begin
        dll_q <= WR_DATA;
      end else if (dlab && ADDR == `UIES_A_IER) begin
        dlm_q <= WR_DATA;
      end else if (dlab && ADDR == `UIES_A_ISR) begin
        if (enh) begin
          dld_q <= WR_DATA;
        end
      end else begin
        unique case (ADDR)
          `UIES_A_IER: ier_q <= {enh ? WR_DATA[7:4] : ier_q[7:4], WR_DATA[3:0]};
          `UIES_A_ISR: begin
            // fifo enable must be set for other bits to take
            if (WR_DATA[`UIES_FCR_EN]) begin
              fcr_q <= {WR_DATA[7:6], enh ? WR_DATA[5:4] : fcr_q[5:4], WR_DATA[3], 2'b00, 1'b1};
            end else begin
              fcr_q[`UIES_FCR_EN] <= 1'b0;
            end
          end
          `UIES_A_MCR: mcr_q <= {enh ? WR_DATA[7:5] : mcr_q[7:5], WR_DATA[4:0]};
          `UIES_A_SPR: spr_q <= WR_DATA;
          default: ;
        endcase
      end
    end
  end

  // write side pulses to the channel
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      thr_wr_q <= 1'b0;
      thr_q <= 8'h00;
      rx_rst_q <= 1'b0;
      tx_rst_q <= 1'b0;
    end else begin
      thr_wr_q <= wr_thr;
      if (wr_thr) begin
        thr_q <= WR_DATA;
      end
      rx_rst_q <= wr_fcr & WR_DATA[`UIES_FCR_EN] & WR_DATA[`UIES_FCR_RXRST];
      tx_rst_q <= wr_fcr & WR_DATA[`UIES_FCR_EN] & WR_DATA[`UIES_FCR_TXRST];
    end
  end

  // trigger levels
  always_comb begin
    unique case (fcr_q[7:6])
      2'b00: rx_trig = `UIES_TRIG_0;
      2'b01: rx_trig = `UIES_TRIG_1;
      2'b10: rx_trig = `UIES_TRIG_2;
      2'b11: rx_trig = `UIES_TRIG_3;
    endcase
    unique case (enh ? fcr_q[5:4] : 2'b00)
      2'b00: tx_trig = `UIES_TRIG_1;
      2'b01: tx_trig = `UIES_TRIG_0;
      2'b10: tx_trig = `UIES_TRIG_2;
      2'b11: tx_trig = `UIES_TRIG_3;
    endcase
  end

  assign rx_hit = fifo_on ? (RX_FIFO_LEVEL >= LVL_W'(rx_trig)) : (RX_FIFO_LEVEL != '0);
  assign tx_empty = (TX_FIFO_LEVEL == '0);
  assign tx_event = fifo_on ?
    ((TX_FIFO_LEVEL < LVL_W'(tx_trig) && tx_lvl_q >= LVL_W'(tx_trig)) || (tx_empty && tx_lvl_q != '0)) :
    (tx_empty && tx_lvl_q != '0);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ovr_q <= 1'b0;
      ls_pend_q <= 1'b0;
    end else begin
      if (RX_OVERRUN) begin
        ovr_q <= 1'b1;
      end else if (rd_lsr) begin
        ovr_q <= 1'b0;
      end
      // overrun immediate, head errors on arrival
      if (RX_OVERRUN || (RX_HEAD_NEW && RX_HEAD_ERR != 3'h0)) begin
        ls_pend_q <= 1'b1;
      end else if (rd_lsr) begin
        ls_pend_q <= 1'b0;
      end
    end
  end

  // character timeout timer in bit times
  assign to_lim = `UIES_TO_CHARS * (7'h07 + {5'h00, lcr_q[1:0]} + {6'h00, lcr_q[3]} + {6'h00, lcr_q[2]})
    + `UIES_TO_BITS;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      to_cnt_q <= 7'h00;
      to_q <= 1'b0;
    end else begin
      if (RX_CHAR_LOADED || rd_rhr || !fifo_on || RX_FIFO_LEVEL == '0) begin
        to_cnt_q <= 7'h00;
      end else if (BIT_TICK && to_cnt_q != to_lim) begin
        to_cnt_q <= to_cnt_q + 7'h01;
      end
      if (fifo_on && RX_FIFO_LEVEL != '0 && BIT_TICK && to_cnt_q + 7'h01 == to_lim) begin
        to_q <= 1'b1;
      end else if (rd_rhr || !fifo_on) begin
        to_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_lvl_q <= '0;
      tx_pend_q <= 1'b0;
    end else begin
      tx_lvl_q <= TX_FIFO_LEVEL;
      if (tx_event || (wr_ier && WR_DATA[1] && !ier_q[1] && tx_empty)) begin
        tx_pend_q <= 1'b1;
      // cleared by status read or holding write
      end else if ((rd_isr && src == uies_pkg::UIES_SRC_TX) || wr_thr) begin
        tx_pend_q <= 1'b0;
      end
    end
  end

  // modem pin synchronisers
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pin_s1_q <= 4'hf;
      pin_s2_q <= 4'hf;
      pin_s3_q <= 4'hf;
    end else begin
      pin_s1_q <= {CD_N, RI_N, DSR_N, CTS_N};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      msr_delta_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (i == 2 ? (pin_s2_q[i] & ~pin_s3_q[i]) : (pin_s2_q[i] ^ pin_s3_q[i])) begin
          msr_delta_q[i] <= 1'b1;
        end else if (rd_msr) begin
          msr_delta_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      xoff_pend_q <= 1'b0;
      spec_pend_q <= 1'b0;
    end else begin
      if (XOFF_DET) begin
        xoff_pend_q <= 1'b1;
      end else if ((rd_isr && src == uies_pkg::UIES_SRC_XOFF) || XON_DET) begin
        xoff_pend_q <= 1'b0;
      end
      if (SPECIAL_DET && efr_q[`UIES_EFR_SPEC]) begin
        spec_pend_q <= 1'b1;
      end else if ((rd_isr && src == uies_pkg::UIES_SRC_XOFF) || RX_CHAR_LOADED) begin
        spec_pend_q <= 1'b0;
      end
    end
  end

  // rts rising, cts rising, cleared by modem status read
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rts_q <= 1'b1;
      flow_pend_q <= 1'b0;
    end else begin
      rts_q <= RTS_N_STATE;
      if ((efr_q[`UIES_EFR_ARTS] && RTS_N_STATE && !rts_q) ||
          (efr_q[`UIES_EFR_ACTS] && pin_s2_q[0] && !pin_s3_q[0])) begin
        flow_pend_q <= 1'b1;
      end else if (rd_msr) begin
        flow_pend_q <= 1'b0;
      end
    end
  end

  // enabled sources
  assign ls_on = ier_eff[2] & ls_pend_q;
  assign to_on = ier_eff[0] & to_q;
  assign rx_on = ier_eff[0] & rx_hit;
  assign tx_on = ier_eff[1] & tx_pend_q;
  assign ms_on = ier_eff[3] & (msr_delta_q != 4'h0);
  assign xo_on = ier_eff[5] & (xoff_pend_q | spec_pend_q);
  assign fl_on = ier_eff[6] & ier_eff[7] ? flow_pend_q : (ier_eff[6] | ier_eff[7]) & flow_pend_q;

  always_comb begin
    if (ls_on) begin
      src = uies_pkg::UIES_SRC_LS;
      isr_code = `UIES_ISR_LS;
    end else if (to_on) begin
      src = uies_pkg::UIES_SRC_TO;
      isr_code = `UIES_ISR_TO;
    end else if (rx_on) begin
      src = uies_pkg::UIES_SRC_RX;
      isr_code = `UIES_ISR_RX;
    end else if (tx_on) begin
      src = uies_pkg::UIES_SRC_TX;
      isr_code = `UIES_ISR_TX;
    end else if (ms_on) begin
      src = uies_pkg::UIES_SRC_MS;
      isr_code = `UIES_ISR_MS;
    end else if (xo_on) begin
      src = uies_pkg::UIES_SRC_XOFF;
      isr_code = `UIES_ISR_XOFF;
    end else if (fl_on) begin
      src = uies_pkg::UIES_SRC_FLOW;
      isr_code = `UIES_ISR_FLOW;
    end else begin
      // idle reads one in bit 0
      src = uies_pkg::UIES_SRC_NONE;
      isr_code = `UIES_ISR_NONE;
    end
  end

  // data ready, transmit empties, global error
  assign line_status_reg = {fifo_on & RX_FIFO_HAS_ERR, tx_empty & TSR_EMPTY, tx_empty,
    RX_HEAD_ERR, ovr_q, RX_FIFO_LEVEL != '0};

  // read data mux
  always_comb begin
    rd_d = 8'h00;
    if (ADDR == `UIES_A_LCR) begin
      rd_d = lcr_q;
    end else if (enh_bank) begin
      unique case (ADDR)
        `UIES_A_EFR: rd_d = efr_q;
        `UIES_A_XON_CHAR_FIRST: rd_d = xon_char_first_q;
        `UIES_A_XON_CHAR_SECOND: rd_d = xon_char_second_q;
        `UIES_A_XOFF_CHAR_FIRST: rd_d = xoff_char_first_q;
        `UIES_A_XOFF_CHAR_SECOND: rd_d = xoff_char_second_q;
        default: rd_d = 8'h00;
      endcase
    end else if (dlab && ADDR == `UIES_A_DATA) begin
      rd_d = dll_q;
    end else if (dlab && ADDR == `UIES_A_IER) begin
      rd_d = dlm_q;
    end else if (dlab && ADDR == `UIES_A_ISR) begin
      rd_d = dld_q;
    end else begin
      unique case (ADDR)
        `UIES_A_DATA: rd_d = RX_HEAD_DATA;
        `UIES_A_IER: rd_d = ier_eff;
        `UIES_A_ISR: rd_d = {{2{fifo_on}}, isr_code & {enh, enh, 4'hf}};
        `UIES_A_MCR: rd_d = mcr_q;
        `UIES_A_LSR: rd_d = line_status_reg;
        `UIES_A_MSR: rd_d = {~pin_s2_q, msr_delta_q};
        `UIES_A_SPR: rd_d = spr_q;
        default: rd_d = 8'h00;
      endcase
    end
  end

  // read data and interrupt line
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_q <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      rd_q <= RD_STB ? rd_d : 8'h00;
      irq_q <= (src != uies_pkg::UIES_SRC_NONE);
    end
  end

  assign RD_DATA = rd_q;
  assign IRQ = irq_q;
  assign RHR_RD = rd_rhr;
  assign THR_WR = thr_wr_q;
  assign THR_DATA = thr_q;
  assign RX_FIFO_RST = rx_rst_q;
  assign TX_FIFO_RST = tx_rst_q;
  assign FIFO_EN = fifo_on;
  assign POLLED_MODE = fifo_on & (ier_q[3:0] == 4'h0);
  assign SLEEP_EN = ier_eff[4];
  assign LINE_CTRL = lcr_q;
  assign MODEM_CTRL = {mcr_q[7:5] & {3{enh}}, mcr_q[4:0]};
  assign ENH_CTRL = efr_q;
  assign DIVISOR = {dlm_q, dll_q};
  assign DIV_FRAC = dld_q & {8{enh}};
  assign FLOW_CHARS = {xoff_char_second_q, xoff_char_first_q, xon_char_second_q, xon_char_first_q};
endmodule

// ### uies_defs.svh
// register offsets, bit positions and codes of the interrupt enable and status block
`ifndef UIES_DEFS_SVH
`define UIES_DEFS_SVH
`define UIES_A_DATA 3'h0
`define UIES_A_IER 3'h1
`define UIES_A_ISR 3'h2
`define UIES_A_LCR 3'h3
`define UIES_A_MCR 3'h4
`define UIES_A_LSR 3'h5
`define UIES_A_MSR 3'h6
`define UIES_A_SPR 3'h7
`define UIES_A_EFR 3'h2
`define UIES_A_XON_CHAR_FIRST 3'h4
`define UIES_A_XON_CHAR_SECOND 3'h5
`define UIES_A_XOFF_CHAR_FIRST 3'h6
`define UIES_A_XOFF_CHAR_SECOND 3'h7
`define UIES_LCR_ENH 8'hbf
`define UIES_LCR_DLAB 7
`define UIES_EFR_ENH 4
`define UIES_EFR_SPEC 5
`define UIES_EFR_ARTS 6
`define UIES_EFR_ACTS 7
`define UIES_FCR_EN 0
`define UIES_FCR_RXRST 1
`define UIES_FCR_TXRST 2
`define UIES_ISR_LS 6'h06
`define UIES_ISR_TO 6'h0c
`define UIES_ISR_RX 6'h04
`define UIES_ISR_TX 6'h02
`define UIES_ISR_MS 6'h00
`define UIES_ISR_XOFF 6'h10
`define UIES_ISR_FLOW 6'h20
`define UIES_ISR_NONE 6'h01
`define UIES_TRIG_0 6'h08
`define UIES_TRIG_1 6'h10
`define UIES_TRIG_2 6'h18
`define UIES_TRIG_3 6'h1e
`define UIES_TO_CHARS 7'h04
`define UIES_TO_BITS 7'h0c
`define UIES_LCR_RST 8'h00
`define UIES_ISR_RST 8'h01
`endif

// ### uies_pkg.sv
// types shared by the interrupt enable and status block
package uies_pkg;
  typedef logic [7:0] uies_byte_t;
  typedef enum logic [2:0] {
    UIES_SRC_LS, UIES_SRC_TO, UIES_SRC_RX, UIES_SRC_TX,
    UIES_SRC_MS, UIES_SRC_XOFF, UIES_SRC_FLOW, UIES_SRC_NONE
  } uies_src_t;
endpackage

// ### uies_core_asserts.sv
// concurrent checks on the ports of the interrupt enable and status block
module uies_core_asserts #(
  parameter int LVL_W = 6
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // register port
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic [7:0] RD_DATA,
  // channel status
  input wire logic [LVL_W-1:0] RX_FIFO_LEVEL,
  input wire logic [2:0] RX_HEAD_ERR,
  input wire logic RX_CHAR_LOADED,
  input wire logic RX_FIFO_HAS_ERR,
  input wire logic XON_DET,
  input wire logic [LVL_W-1:0] TX_FIFO_LEVEL,
  input wire logic TSR_EMPTY,
  input wire logic CTS_N,
  // outputs watched
  input wire logic IRQ,
  input wire logic FIFO_EN,
  input wire logic [7:0] LINE_CTRL,
  input wire logic [7:0] ENH_CTRL
);
  logic [7:0] ier_q;
  logic tx_idle;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  assign tx_idle = (TX_FIFO_LEVEL == '0) && TSR_EMPTY;
  // shadow of the enable mask
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ier_q <= 8'h00;
    end else if (WR_STB && ADDR == 3'h1 && !LINE_CTRL[7]) begin
      ier_q <= {ENH_CTRL[4] ? WR_DATA[7:4] : ier_q[7:4], WR_DATA[3:0]};
    end
  end
  sequence isr_rd_s;
    RD_STB && ADDR == 3'h2 && !LINE_CTRL[7];
  endsequence
  sequence lsr_rd_s;
    RD_STB && ADDR == 3'h5 && !LINE_CTRL[7];
  endsequence
  sequence quiet_s;
    !$past(RD_STB) && !$past(WR_STB) && !$past(RX_CHAR_LOADED) && !$past(XON_DET)
      && $stable(RX_FIFO_LEVEL) && $stable(TX_FIFO_LEVEL);
  endsequence
  isr_none_a: assert property ((ier_q == 8'h00) [*2] ##0 isr_rd_s |=> RD_DATA[5:0] == 6'h01)
    else $error("status read with nothing enabled shows a source");
  isr_pend_a: assert property (isr_rd_s ##0 IRQ ##0 quiet_s |=> !RD_DATA[0])
    else $error("status read while interrupting shows none pending");
  isr_fifo_a: assert property (isr_rd_s |=> RD_DATA[7:6] == {2{$past(FIFO_EN)}})
    else $error("status fifo bits differ from fifo enable");
  lsr_err_a: assert property (lsr_rd_s |=> RD_DATA[4:2] == $past(RX_HEAD_ERR))
    else $error("line status error bits differ from head char");
  lsr_global_a: assert property (lsr_rd_s |=> RD_DATA[7] == $past(RX_FIFO_HAS_ERR && FIFO_EN))
    else $error("line status global error wrong");
  lsr_temt_a: assert property (lsr_rd_s |=> RD_DATA[6] == $past(tx_idle))
    else $error("line status transmitter empty wrong");
  lsr_clear_a: assert property (RX_FIFO_LEVEL == '0 ##1 lsr_rd_s ##0 RX_FIFO_LEVEL == '0 |=> !RD_DATA[0])
    else $error("data ready set with empty fifo");
  lsr_set_a: assert property (RX_CHAR_LOADED && !RD_STB ##1 lsr_rd_s |=> RD_DATA[0])
    else $error("data ready not set after char loaded");
  tx_enable_a: assert property (WR_STB && ADDR == 3'h1 && !LINE_CTRL[7] && WR_DATA[1] && !ier_q[1]
    && TX_FIFO_LEVEL == '0 |-> ##[1:2] IRQ)
    else $error("no interrupt after transmit enable while empty");
  ms_irq_a: assert property (ier_q[3] && $changed(CTS_N) ##1 (ier_q[3]) [*4] |-> IRQ)
    else $error("no interrupt after modem pin change");
  irq_off_a: assert property ((ier_q == 8'h00) [*2] |-> !IRQ)
    else $error("interrupt with all sources disabled");
endmodule
bind uies_core uies_core_asserts #(.LVL_W(LVL_W)) u_uies_core_asserts (
  .CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_STB(WR_STB),
  .RD_STB(RD_STB), .RD_DATA(RD_DATA), .RX_FIFO_LEVEL(RX_FIFO_LEVEL), .RX_HEAD_ERR(RX_HEAD_ERR),
  .RX_CHAR_LOADED(RX_CHAR_LOADED), .RX_FIFO_HAS_ERR(RX_FIFO_HAS_ERR), .XON_DET(XON_DET),
  .TX_FIFO_LEVEL(TX_FIFO_LEVEL),
  .TSR_EMPTY(TSR_EMPTY), .CTS_N(CTS_N), .IRQ(IRQ), .FIFO_EN(FIFO_EN), .LINE_CTRL(LINE_CTRL),
  .ENH_CTRL(ENH_CTRL)
);

// ### uies_chan_model.sv
// behavioural receive fifo count of the channel beside the block
module uies_chan_model #(
  parameter int LVL_W = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // char arrival and holding reads
  input wire logic push,
  input wire logic pop,
  // fifo state seen by the block
  output logic [LVL_W-1:0] rx_level,
  output logic loaded
);
  // load pulse and count move on the same edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_level <= '0;
      loaded <= 1'b0;
    end else begin
      loaded <= push;
      rx_level <= rx_level + LVL_W'(push) - LVL_W'(pop && rx_level != '0);
    end
  end
endmodule

// ### uart_interrupt_enable_status_tb_top.sv
// self-checking bench of the interrupt enable and status block
module uart_interrupt_enable_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wr_data = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] head_data = 8'h00;
  logic [2:0] head_err = 3'h0;
  logic head_new = 1'b0;
  logic overrun = 1'b0;
  logic has_err = 1'b0;
  logic [5:0] tx_level = 6'h00;
  logic tsr_empty = 1'b1;
  logic push = 1'b0;
  logic [3:0] pins_n = 4'hf;
  logic bit_tick = 1'b0;
  logic xoff_det = 1'b0;
  logic polled;
  logic sleep_en;
  logic [7:0] rd_data;
  logic [5:0] rx_level;
  logic loaded;
  logic irq;
  logic rhr_rd;
  logic [31:0] flow_chars;
  logic [31:0] xchars;
  logic [7:0] seen;
  int error_cnt = 0;
  int check_count = 0;
  always #5 clk = ~clk;
  uies_core dut (
    .CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WR_DATA(wr_data), .WR_STB(wr_stb), .RD_STB(rd_stb),
    .RD_DATA(rd_data), .RX_FIFO_LEVEL(rx_level), .RX_HEAD_DATA(head_data), .RX_HEAD_ERR(head_err),
    .RX_HEAD_NEW(head_new), .RX_CHAR_LOADED(loaded), .RX_OVERRUN(overrun), .RX_FIFO_HAS_ERR(has_err),
    .XOFF_DET(xoff_det), .XON_DET(1'b0), .SPECIAL_DET(1'b0), .BIT_TICK(bit_tick), .TX_FIFO_LEVEL(tx_level),
    .TSR_EMPTY(tsr_empty), .RTS_N_STATE(1'b1), .CTS_N(pins_n[0]), .DSR_N(pins_n[1]), .RI_N(pins_n[2]),
    .CD_N(pins_n[3]), .IRQ(irq), .RHR_RD(rhr_rd), .THR_WR(), .THR_DATA(), .RX_FIFO_RST(), .TX_FIFO_RST(),
    .FIFO_EN(), .POLLED_MODE(polled), .SLEEP_EN(sleep_en), .LINE_CTRL(), .MODEM_CTRL(), .ENH_CTRL(), .DIVISOR(),
    .DIV_FRAC(), .FLOW_CHARS(flow_chars)
  );
  uies_chan_model chan (
    .clk(clk), .reset_n(reset_n), .push(push), .pop(rhr_rd), .rx_level(rx_level), .loaded(loaded)
  );
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] isr_fifo(input logic [5:0] code);
    return {2'b11, code};
  endfunction
  // timeout span in bit times: four characters of start, word, stop and parity bits plus twelve
  function automatic int to_ticks(input logic [7:0] line_control_reg);
    return 4 * (7 + line_control_reg[1:0] + line_control_reg[2] + line_control_reg[3]) + 12;
  endfunction
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    d = rd_data;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    check(d & m, e);
  endtask
  task automatic push_chars(input int n);
    repeat (n) begin
      @(posedge clk);
      push <= 1'b1;
      @(posedge clk);
      push <= 1'b0;
    end
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h161c9f14));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rd_chk(3'h2, 8'hff, 8'h01);
    rd_chk(3'h1, 8'hff, 8'h00);
    wr(3'h1, 8'hff);
    rd_chk(3'h1, 8'hff, 8'h0f);
    check(sleep_en, 1'b0);
    wr(3'h3, 8'hbf);
    wr(3'h2, 8'h10);
    for (int i = 0; i < 4; i++) begin
      xchars[8*i +: 8] = 8'($urandom);
      wr(3'(4 + i), xchars[8*i +: 8]);
    end
    for (int i = 0; i < 4; i++) rd_chk(3'(4 + i), 8'hff, xchars[8*i +: 8]);
    check(flow_chars, xchars);
    wr(3'h3, 8'h00);
    wr(3'h1, 8'hff);
    rd_chk(3'h1, 8'hff, 8'hff);
    check(sleep_en, 1'b1);
    check(irq, 1'b1);
    rd_chk(3'h2, 8'hff, 8'h02);
    rd_chk(3'h2, 8'hff, 8'h01);
    check(irq, 1'b0);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h01);
    push_chars(1);
    rd_chk(3'h5, 8'h01, 8'h01);
    check(polled, 1'b1);
    check(irq, 1'b0);
    wr(3'h1, 8'h01);
    push_chars(6);
    rd_chk(3'h2, 8'hff, isr_fifo(6'h01));
    check(polled, 1'b0);
    push_chars(1);
    repeat (2) @(posedge clk);
    check(irq, 1'b1);
    rd_chk(3'h2, 8'hff, isr_fifo(6'h04));
    rd(3'h0, seen);
    rd_chk(3'h2, 8'hff, isr_fifo(6'h01));
    repeat (7) rd(3'h0, seen);
    rd_chk(3'h5, 8'h01, 8'h00);
    push_chars(1);
    bit_tick <= 1'b1;
    repeat (to_ticks(8'h00) + 1) @(posedge clk);
    check(irq, 1'b0);
    repeat (2) @(posedge clk);
    check(irq, 1'b1);
    bit_tick <= 1'b0;
    rd_chk(3'h2, 8'hff, isr_fifo(6'h0c));
    rd(3'h0, seen);
    rd_chk(3'h2, 8'hff, isr_fifo(6'h01));
    wr(3'h1, 8'h05);
    push_chars(8);
    @(posedge clk);
    overrun <= 1'b1;
    has_err <= 1'b1;
    @(posedge clk);
    overrun <= 1'b0;
    repeat (2) @(posedge clk);
    check(irq, 1'b1);
    rd_chk(3'h2, 8'hff, isr_fifo(6'h06));
    rd_chk(3'h5, 8'h82, 8'h82);
    rd_chk(3'h2, 8'hff, isr_fifo(6'h04));
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      head_err <= 3'(1 << i);
      head_new <= 1'b1;
      head_data <= 8'($urandom);
      @(posedge clk);
      head_new <= 1'b0;
      rd_chk(3'h2, 8'hff, isr_fifo(6'h06));
      rd_chk(3'h5, 8'h1c, 8'(4 << i));
      rd_chk(3'h2, 8'hff, isr_fifo(6'h04));
    end
    @(posedge clk);
    head_err <= 3'h0;
    has_err <= 1'b0;
    repeat (8) rd(3'h0, seen);
    wr(3'h1, 8'h00);
    tx_level <= 6'(1 + $urandom_range(62));
    tsr_empty <= 1'b0;
    rd_chk(3'h5, 8'he0, 8'h00);
    @(posedge clk);
    tx_level <= 6'h00;
    tsr_empty <= 1'b1;
    rd_chk(3'h5, 8'h60, 8'h60);
    wr(3'h1, 8'h02);
    rd_chk(3'h2, 8'hff, isr_fifo(6'h02));
    @(posedge clk);
    tx_level <= 6'h14;
    @(posedge clk);
    tx_level <= 6'h0a;
    repeat (3) @(posedge clk);
    rd_chk(3'h2, 8'hff, isr_fifo(6'h02));
    @(posedge clk);
    tx_level <= 6'h00;
    repeat (3) @(posedge clk);
    check(irq, 1'b1);
    wr(3'h0, head_data);
    rd_chk(3'h2, 8'hff, isr_fifo(6'h01));
    @(posedge clk);
    pins_n <= 4'h0;
    repeat (4) @(posedge clk);
    rd(3'h6, seen);
    wr(3'h1, 8'h08);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      pins_n[i] <= 1'b1;
      repeat (6) @(posedge clk);
      check(irq, 1'b1);
      rd_chk(3'h2, 8'hff, isr_fifo(6'h00));
      rd_chk(3'h6, 8'h0f, 8'(1 << i));
      rd_chk(3'h2, 8'hff, isr_fifo(6'h01));
    end
    wr(3'h1, 8'h20);
    @(posedge clk);
    xoff_det <= 1'b1;
    @(posedge clk);
    xoff_det <= 1'b0;
    rd_chk(3'h2, 8'hff, isr_fifo(6'h10));
    rd_chk(3'h2, 8'hff, isr_fifo(6'h01));
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd_chk(3'h1, 8'hff, 8'h00);
    rd_chk(3'h2, 8'hff, 8'h01);
    tally_and_finish();
  end
endmodule
